/* rtl/dmacc_top.sv */
// module: dma channel configuration registers and identification block
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Functional notes
// - bits 31:19, 10 and 5 reserved; read as zero, write zero
// - halt bit 18 set makes channel ignore further source requests
// - while halted the fifo still drains to the destination
// - bit 17 read-only, shows fifo holds data; writes ignored
// - lock bit 16 makes channel bus transfers locked
// - bit 15 clear suppresses terminal count interrupt
// - bit 14 clear suppresses error interrupt
// - flow field 13:11 codes 0-3 are controller-paced transfer types
// - codes 4-7 are paced by destination, peripheral or source
// - destination select 9:6 picks request line, ignored for memory
// - source select 4:1 picks request line, ignored for memory
// - select fields hold binary line index, not a one-hot mask
// - bit 0 reads enable state; writing one enables channel
// - enable state also readable in enabled channels register
// - clearing enable finishes current transfer, then drops fifo data
// - channel disables itself on last list item or on error
// - four read-only 8-bit ident registers at 0xfe0 to 0xfec
// - ident bits: part 11:0, designer 19:12, configuration 31:24
// - ident bits 23:20 are revision, starting at zero
// - ident registers hard-wired; only low 8 bits defined
// - channel config registers at 0x110 and 0x130
// - config registers change only by software writes
module dmacc_top
  import dmacc_pkg::*;
#(
  parameter logic [11:0] PART_CODE   = 12'h5a3, // arbitrary value
  parameter logic [7:0]  DESIGNER    = 8'h6c,   // arbitrary value
  parameter logic [3:0]  REVISION    = 4'h3,    // arbitrary value
  parameter logic [7:0]  CONFIG_OPT  = 8'h02    // arbitrary value
)
(
  input  wire logic                         MCLK_IN,
  input  wire logic                         RESETN_IN,
  input  wire logic                         WB_CYC_IN,
  input  wire logic                         WB_STB_IN,
  input  wire logic                         WB_WE_IN,
  input  wire logic [11:0]                  WB_ADR_IN,
  input  wire logic [3:0]                   WB_SEL_IN,
  input  wire logic [31:0]                  WB_DAT_IN,
  output logic      [31:0]                  WB_DAT_OUT,
  output logic                              WB_ACK_OUT,
  input  wire logic [REQ_LINES-1:0]         DMA_REQ_IN,
  input  wire dmacc_stat_type [NUM_CH-1:0]  CH_STAT_IN,
  output dmacc_ctl_type       [NUM_CH-1:0]  CH_CTL_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // config register offset of a channel
  function automatic logic [11:0] cfg_ofs(input int unsigned ch);
    cfg_ofs = (ch == 0) ? CFG0_OFS : CFG1_OFS;
  endfunction : cfg_ofs

  // byte-lane mask from wishbone select
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  localparam logic [31:0] IDENT_VAL = {CONFIG_OPT, REVISION,
                                       DESIGNER, PART_CODE};

  logic                   ack_r;
  logic [31:0]            dat_r;
  logic [31:0]            rd_nxt;
  logic                   req_new;
  logic                   wr_go;
  logic [31:0]            wr_mask;
  logic [31:0]            cfg_r      [NUM_CH];
  logic [NUM_CH-1:0]      chan_on;
  logic [NUM_CH-1:0]      sw_set;
  logic [NUM_CH-1:0]      sw_clr;
  logic [NUM_CH-1:0]      cfg_hit;
  logic [NUM_CH-1:0]      src_req;
  logic [NUM_CH-1:0]      dst_req;
  logic [NUM_CH-1:0]      flush;
  logic [NUM_CH-1:0]      tc_irq_r;
  logic [NUM_CH-1:0]      err_irq_r;
  logic [NUM_CH-1:0]      lock_r;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave handshake

  // a new request is one not yet answered
  assign req_new = WB_CYC_IN && WB_STB_IN && !ack_r;
  assign wr_go   = req_new && WB_WE_IN;
  // only storable bits in enabled lanes
  assign wr_mask = lane_mask(WB_SEL_IN) & CFG_WR_MASK;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) ack_r <= 1'b0;
    else ack_r <= req_new;
  end

  // read data captured with the ack
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) dat_r <= 32'h0000_0000;
    else if (req_new && !WB_WE_IN) dat_r <= rd_nxt;
  end

  assign WB_ACK_OUT = ack_r;
  assign WB_DAT_OUT = dat_r;

  ////////////////////////////////////////////////////////////////////////////
  // read multiplexer

  // reserved bits and unmapped offsets read as zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    for (int unsigned c = 0; c < NUM_CH; c++) begin
      if (WB_ADR_IN == cfg_ofs(c)) begin
        rd_nxt = cfg_r[c] & CFG_WR_MASK;
        rd_nxt[ACTIVE_BIT] = CH_STAT_IN[c].fifo_has_data;
        rd_nxt[ENABLE_BIT] = chan_on[c];
      end
    end
    unique case (WB_ADR_IN)
      ENBL_OFS:   rd_nxt = {{(32-NUM_CH){1'b0}}, chan_on};
      IDENT0_OFS: rd_nxt = {24'h00_0000, IDENT_VAL[7:0]};
      IDENT1_OFS: rd_nxt = {24'h00_0000, IDENT_VAL[15:8]};
      IDENT2_OFS: rd_nxt = {24'h00_0000, IDENT_VAL[23:16]};
      IDENT3_OFS: rd_nxt = {24'h00_0000, IDENT_VAL[31:24]};
      default: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel registers and control

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign cfg_hit[i] = (WB_ADR_IN == cfg_ofs(i));

    // config storage written only by software; list loads never touch it
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
        cfg_r[i] <= CFG_RST;
      end else if (wr_go && cfg_hit[i]) begin
        cfg_r[i] <= (cfg_r[i] & ~wr_mask) | (WB_DAT_IN & wr_mask);
      end
    end

    // enable bit writes become set and clear commands
    assign sw_set[i] = wr_go && cfg_hit[i] && WB_SEL_IN[0] &&
                       WB_DAT_IN[ENABLE_BIT];
    assign sw_clr[i] = wr_go && cfg_hit[i] && WB_SEL_IN[0] &&
                       !WB_DAT_IN[ENABLE_BIT];

    // enable state machine
    dmacc_chan_ctl u_ctl (
      .clk_in       (MCLK_IN),
      .rst_n_in     (RESETN_IN),
      .sw_set_in    (sw_set[i]),
      .sw_clr_in    (sw_clr[i]),
      .xfer_busy_in (CH_STAT_IN[i].xfer_busy),
      .last_lli_in  (CH_STAT_IN[i].last_lli_done),
      .error_in     (CH_STAT_IN[i].chan_error),
      .enabled_out  (chan_on[i]),
      .flush_out    (flush[i])
    );

    // request line selection and halt gating
    dmacc_req_gate u_gate (
      .clk_in       (MCLK_IN),
      .rst_n_in     (RESETN_IN),
      .req_lines_in (DMA_REQ_IN),
      .enable_in    (chan_on[i]),
      .halt_in      (cfg_r[i][HALT_BIT]),
      .flow_in      (cfg_r[i][FLOW_LSB +: 3]),
      .src_sel_in   (cfg_r[i][SRC_LSB +: SEL_W]),
      .dst_sel_in   (cfg_r[i][DST_LSB +: SEL_W]),
      .src_req_out  (src_req[i]),
      .dst_req_out  (dst_req[i])
    );

    // interrupt masking, registered
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
        tc_irq_r[i]  <= 1'b0;
        err_irq_r[i] <= 1'b0;
      end else begin
        tc_irq_r[i]  <= CH_STAT_IN[i].tc_irq_raw && cfg_r[i][TCM_BIT];
        err_irq_r[i] <= CH_STAT_IN[i].err_irq_raw && cfg_r[i][ERRM_BIT];
      end
    end

    // locked transfers only while the channel runs
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) lock_r[i] <= 1'b0;
      else lock_r[i] <= cfg_r[i][LOCK_BIT] && chan_on[i];
    end

    // control bundle towards the datapath
    assign CH_CTL_OUT[i].enable     = chan_on[i];
    assign CH_CTL_OUT[i].halt       = cfg_r[i][HALT_BIT];
    assign CH_CTL_OUT[i].lock       = lock_r[i];
    assign CH_CTL_OUT[i].flow       = cfg_r[i][FLOW_LSB +: 3];
    assign CH_CTL_OUT[i].src_req    = src_req[i];
    assign CH_CTL_OUT[i].dst_req    = dst_req[i];
    assign CH_CTL_OUT[i].tc_irq     = tc_irq_r[i];
    assign CH_CTL_OUT[i].err_irq    = err_irq_r[i];
    assign CH_CTL_OUT[i].fifo_flush = flush[i];

    a_tc_mask_gate: assert property (
      @(posedge MCLK_IN) disable iff (!RESETN_IN)
      !cfg_r[i][TCM_BIT] |=> !CH_CTL_OUT[i].tc_irq)
      else $error("terminal count interrupt passed while masked");
    a_err_mask_gate: assert property (
      @(posedge MCLK_IN) disable iff (!RESETN_IN)
      (CH_STAT_IN[i].err_irq_raw && cfg_r[i][ERRM_BIT])
        |=> CH_CTL_OUT[i].err_irq)
      else $error("unmasked error interrupt not passed");
    a_lock_follows_cfg: assert property (
      @(posedge MCLK_IN) disable iff (!RESETN_IN)
      (cfg_r[i][LOCK_BIT] && chan_on[i]) |=> CH_CTL_OUT[i].lock)
      else $error("lock not asserted for locked channel");
    a_active_reads_fifo: assert property (
      @(posedge MCLK_IN) disable iff (!RESETN_IN)
      (req_new && !WB_WE_IN && cfg_hit[i])
        |=> WB_DAT_OUT[ACTIVE_BIT] == $past(CH_STAT_IN[i].fifo_has_data))
      else $error("active bit does not show fifo state");
    a_cfg_reserved_zero: assert property (
      @(posedge MCLK_IN) disable iff (!RESETN_IN)
      (req_new && !WB_WE_IN && cfg_hit[i])
        |=> (WB_DAT_OUT[31:19] == 13'h0000) && !WB_DAT_OUT[10] &&
            !WB_DAT_OUT[5])
      else $error("reserved config bits read nonzero");
    a_enable_read_back: assert property (
      @(posedge MCLK_IN) disable iff (!RESETN_IN)
      (req_new && !WB_WE_IN && cfg_hit[i])
        |=> WB_DAT_OUT[ENABLE_BIT] == $past(chan_on[i]))
      else $error("enable bit read differs from channel state");
    a_cfg_sw_only: assert property (
      @(posedge MCLK_IN) disable iff (!RESETN_IN)
      !(wr_go && cfg_hit[i]) |=> $stable(cfg_r[i]))
      else $error("config changed without a software write");
  end : g_ch

  ////////////////////////////////////////////////////////////////////////////
  // bus and identification checks

  a_ack_one_cycle: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    req_new |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
    else $error("ack not a single cycle after request");
  a_enbl_mirror_read: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    (req_new && !WB_WE_IN && WB_ADR_IN == ENBL_OFS)
      |=> WB_DAT_OUT[NUM_CH-1:0] == $past(chan_on))
    else $error("enabled channels register differs from state");
  a_ident_byte_read: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    (req_new && !WB_WE_IN && WB_ADR_IN == IDENT2_OFS)
      |=> WB_DAT_OUT == {24'h00_0000, REVISION, DESIGNER[7:4]})
    else $error("ident byte two read wrong value");
  a_ident_part_read: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    (req_new && !WB_WE_IN && WB_ADR_IN == IDENT0_OFS)
      |=> WB_DAT_OUT == {24'h00_0000, PART_CODE[7:0]})
    else $error("ident byte zero read wrong value");
endmodule : dmacc_top
`default_nettype wire

/* rtl/dmacc_pkg.sv */
// package: register map, field layout and types of the dma channel config
`default_nettype none
package dmacc_pkg;
  localparam int unsigned NUM_CH     = 2;
  localparam int unsigned REQ_LINES  = 16;
  localparam int unsigned SEL_W      = 4;
  // register offsets, byte addresses
  localparam logic [11:0] CFG0_OFS   = 12'h110;
  localparam logic [11:0] CFG1_OFS   = 12'h130;
  localparam logic [11:0] ENBL_OFS   = 12'h01c;
  localparam logic [11:0] IDENT0_OFS = 12'hfe0;
  localparam logic [11:0] IDENT1_OFS = 12'hfe4;
  localparam logic [11:0] IDENT2_OFS = 12'hfe8;
  localparam logic [11:0] IDENT3_OFS = 12'hfec;
  // channel config field positions
  localparam int unsigned HALT_BIT   = 18;
  localparam int unsigned ACTIVE_BIT = 17;
  localparam int unsigned LOCK_BIT   = 16;
  localparam int unsigned TCM_BIT    = 15;
  localparam int unsigned ERRM_BIT   = 14;
  localparam int unsigned FLOW_LSB   = 11;
  localparam int unsigned DST_LSB    = 6;
  localparam int unsigned SRC_LSB    = 1;
  localparam int unsigned ENABLE_BIT = 0;
  // bits software may store; reserved and status bits excluded
  localparam logic [31:0] CFG_WR_MASK = 32'h0005_fbde;
  localparam logic [31:0] CFG_RST     = 32'h0000_0000;
  // identification field layout in the logical 32-bit value
  localparam int unsigned PART_LSB   = 0;
  localparam int unsigned DSGN_LSB   = 12;
  localparam int unsigned REV_LSB    = 20;
  localparam int unsigned CONF_LSB   = 24;

  // channel enable states
  typedef enum logic [2:0] {
    CH_OFF  = 3'b001,
    CH_ON   = 3'b010,
    CH_STOP = 3'b100
  } dmacc_chst_type;

  // per-channel status from datapath
  typedef struct packed {
    logic fifo_has_data;
    logic xfer_busy;
    logic last_lli_done;
    logic chan_error;
    logic tc_irq_raw;
    logic err_irq_raw;
  } dmacc_stat_type;

  // per-channel control towards datapath
  typedef struct packed {
    logic       enable;
    logic       halt;
    logic       lock;
    logic [2:0] flow;
    logic       src_req;
    logic       dst_req;
    logic       tc_irq;
    logic       err_irq;
    logic       fifo_flush;
  } dmacc_ctl_type;

  // source side is a peripheral for this flow code
  function automatic logic src_is_periph(input logic [2:0] flow);
    src_is_periph = (flow == 3'h2) || (flow == 3'h3) || (flow == 3'h4) ||
                    (flow == 3'h6) || (flow == 3'h7);
  endfunction : src_is_periph

  // destination side is a peripheral for this flow code
  function automatic logic dst_is_periph(input logic [2:0] flow);
    dst_is_periph = (flow == 3'h1) || (flow == 3'h3) || (flow == 3'h4) ||
                    (flow == 3'h5) || (flow == 3'h7);
  endfunction : dst_is_periph
endpackage : dmacc_pkg
`default_nettype wire

/* rtl/dmacc_chan_ctl.sv */
// module: channel enable state machine with clean disable
`default_nettype none
module dmacc_chan_ctl
  import dmacc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic sw_set_in,
  input  wire logic sw_clr_in,
  input  wire logic xfer_busy_in,
  input  wire logic last_lli_in,
  input  wire logic error_in,
  output logic      enabled_out,
  output logic      flush_out
);
  dmacc_chst_type st_r;
  dmacc_chst_type st_nxt;
  logic           flush_r;

  // next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      CH_OFF: begin
        if (sw_set_in) st_nxt = CH_ON;
      end
      CH_ON: begin
        if (last_lli_in || error_in) st_nxt = CH_OFF;
        else if (sw_clr_in) st_nxt = CH_STOP;
      end
      CH_STOP: begin
        if (last_lli_in || error_in || !xfer_busy_in) st_nxt = CH_OFF;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) st_r <= CH_OFF;
    else st_r <= st_nxt;
  end

  // fifo discard pulse when a software stop completes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) flush_r <= 1'b0;
    else flush_r <= (st_r == CH_STOP) && (st_nxt == CH_OFF);
  end

  assign enabled_out = (st_r != CH_OFF);
  assign flush_out   = flush_r;

  a_stop_waits_xfer: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (st_r == CH_STOP && xfer_busy_in && !last_lli_in && !error_in)
      |=> enabled_out && !flush_out)
    else $error("channel stopped while a transfer was in progress");
  a_auto_clear_off: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (last_lli_in || error_in) |=> !enabled_out)
    else $error("channel still enabled after last item or error");
endmodule : dmacc_chan_ctl
`default_nettype wire

/* rtl/dmacc_req_gate.sv */
// module: per-channel selection and gating of dma request lines
`default_nettype none
module dmacc_req_gate
  import dmacc_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic [REQ_LINES-1:0] req_lines_in,
  input  wire logic                 enable_in,
  input  wire logic                 halt_in,
  input  wire logic [2:0]           flow_in,
  input  wire logic [SEL_W-1:0]     src_sel_in,
  input  wire logic [SEL_W-1:0]     dst_sel_in,
  output logic                      src_req_out,
  output logic                      dst_req_out
);
  logic src_req_r;
  logic dst_req_r;

  // select fields are binary line indexes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_req_r <= 1'b0;
      dst_req_r <= 1'b0;
    end else begin
      src_req_r <= enable_in && !halt_in && src_is_periph(flow_in) &&
                   req_lines_in[src_sel_in];
      dst_req_r <= enable_in && dst_is_periph(flow_in) &&
                   req_lines_in[dst_sel_in];
    end
  end

  assign src_req_out = src_req_r;
  assign dst_req_out = dst_req_r;

  a_halt_blocks_src: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    halt_in |=> !src_req_out)
    else $error("source request passed while halted");
  a_mem_src_ignored: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !src_is_periph(flow_in) |=> !src_req_out)
    else $error("source request passed for memory source");
  a_mem_dst_ignored: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !dst_is_periph(flow_in) |=> !dst_req_out)
    else $error("destination request passed for memory destination");
  a_drain_while_halt: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (enable_in && halt_in && dst_is_periph(flow_in) &&
     req_lines_in[dst_sel_in]) |=> dst_req_out)
    else $error("destination not served while halted");
endmodule : dmacc_req_gate
`default_nettype wire

/* bench/dmacc_far_model.sv */
// partner: channel datapath and fifo model behind the config block
`default_nettype none
module dmacc_far_model
  import dmacc_pkg::*;
(
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  input  wire dmacc_ctl_type [NUM_CH-1:0] ctl_in,
  input  wire logic [NUM_CH-1:0]          drain_in,
  input  wire logic [NUM_CH-1:0]          busy_in,
  input  wire logic [NUM_CH-1:0]          lli_in,
  input  wire logic [NUM_CH-1:0]          err_in,
  input  wire logic [NUM_CH-1:0]          irq_in,
  output dmacc_stat_type [NUM_CH-1:0]     stat_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] fill_r [NUM_CH];
  ////////////////////////////////////////////////////////////////////////
  // occupancy: source beats fill, drain runs even while halted
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (!rst_n_in) begin
        fill_r[i] <= 4'h0;
      end else if (ctl_in[i].fifo_flush) begin
        fill_r[i] <= 4'h0;
      end else if (ctl_in[i].src_req && fill_r[i] != 4'hf) begin
        fill_r[i] <= fill_r[i] + 4'h1;
      end else if (drain_in[i] && fill_r[i] != 4'h0) begin
        fill_r[i] <= fill_r[i] - 4'h1;
      end
    end
  end
  // status levels seen by the config block
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      stat_out[i].fifo_has_data = (fill_r[i] != 4'h0);
      stat_out[i].xfer_busy     = busy_in[i];
      stat_out[i].last_lli_done = lli_in[i];
      stat_out[i].chan_error    = err_in[i];
      stat_out[i].tc_irq_raw    = irq_in[i];
      stat_out[i].err_irq_raw   = irq_in[i];
    end
  end
endmodule : dmacc_far_model
`default_nettype wire

/* bench/tb_dma_channel_config_and_ident.sv */
// testbench: register access and channel control checks
`default_nettype none
module tb_dma_channel_config_and_ident;
  timeunit 1ns;
  timeprecision 1ps;
  import dmacc_pkg::*;
  localparam logic [11:0] T_PART  = 12'h5a3; // arbitrary value
  localparam logic [7:0]  T_DSGN  = 8'h6c;   // arbitrary value
  localparam logic [3:0]  T_REV   = 4'h3;    // arbitrary value
  localparam logic [7:0]  T_CONF  = 8'h02;   // arbitrary value
  localparam logic [7:0]  SRC_MAP = 8'b1101_1100;
  localparam logic [7:0]  DST_MAP = 8'b1011_1010;
  logic                        mclk;
  logic                        rst_n = 1'b0;
  logic                        cyc   = 1'b0;
  logic                        wen   = 1'b0;
  logic [11:0]                 adr   = 12'h0;
  logic [31:0]                 wdat  = 32'h0;
  logic [3:0]                  sel   = 4'hf;
  logic [3:0]                  lanes = 4'hf;
  logic [15:0]                 req   = 16'h0;
  logic [NUM_CH-1:0]           drain = 2'b00;
  logic [NUM_CH-1:0]           busy  = 2'b00;
  logic [NUM_CH-1:0]           linked_list_item   = 2'b00;
  logic [NUM_CH-1:0]           err   = 2'b00;
  logic [NUM_CH-1:0]           irq   = 2'b00;
  logic [31:0]                 rdat;
  logic                        ack;
  dmacc_stat_type [NUM_CH-1:0] stat;
  dmacc_ctl_type  [NUM_CH-1:0] ctl;
  int                          bad_count = 0;
  int                          n_checks  = 0;

  dmacc_top #(.PART_CODE(T_PART), .DESIGNER(T_DSGN), .REVISION(T_REV),
    .CONFIG_OPT(T_CONF)) dmacc_top_i (.MCLK_IN(mclk), .RESETN_IN(rst_n),
    .WB_CYC_IN(cyc), .WB_STB_IN(cyc), .WB_WE_IN(wen), .WB_ADR_IN(adr),
    .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack), .DMA_REQ_IN(req), .CH_STAT_IN(stat),
    .CH_CTL_OUT(ctl));
  dmacc_far_model dmacc_far_model_i (.clk_in(mclk), .rst_n_in(rst_n),
    .ctl_in(ctl), .drain_in(drain), .busy_in(busy), .lli_in(linked_list_item),
    .err_in(err), .irq_in(irq), .stat_out(stat));
  ////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    report_and_stop;
  end
  ////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    cyc <= 1'b1;
    wen <= w;
    adr <= a;
    wdat <= d;
    sel <= lanes;
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
  endtask : wb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd
  task automatic look(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : look
  function automatic logic [31:0] cfg(input logic h, l, t, e,
    input logic [2:0] f, input logic [3:0] ds, ss, input logic en);
    cfg = {13'h0, h, 1'b0, l, t, e, f, 1'b0, ds, 1'b0, ss, en};
  endfunction : cfg
  ////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    logic [31:0] v;
    logic [31:0] q;
    logic [31:0] id_exp [4];
    int k;
    id_exp = '{{24'h0, T_PART[7:0]}, {24'h0, T_DSGN[3:0], T_PART[11:8]},
               {24'h0, T_REV, T_DSGN[7:4]}, {24'h0, T_CONF}};
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    // reset state, read-only ident bytes, unmapped space
    rd(CFG0_OFS, 32'h0);
    rd(CFG1_OFS, 32'h0);
    rd(ENBL_OFS, 32'h0);
    for (k = 0; k < 4; k++) begin
      wr(IDENT0_OFS + 12'(4 * k), 32'hffff_ffff);
      rd(IDENT0_OFS + 12'(4 * k), id_exp[k]);
    end
    wr(12'h200, 32'hffff_ffff);
    rd(12'h200, 32'h0);
    // reserved and status bits refuse writes
    v = cfg(1'b0, 1'b1, 1'b1, 1'b0, 3'h0, 4'h9, 4'h7, 1'b1);
    wr(CFG0_OFS, v | 32'hfffa_0420);
    rd(CFG0_OFS, v);
    rd(ENBL_OFS, 32'h1);
    // byte lane one only: enable and low byte untouched
    lanes = 4'h2;
    wr(CFG0_OFS, 32'h0);
    lanes = 4'hf;
    rd(CFG0_OFS, v & 32'hffff_00ff);
    // every flow code against request lines 7 and 9
    req <= 16'h0280;
    for (k = 0; k < 8; k++) begin
      wr(CFG0_OFS, cfg(1'b0, 1'b1, 1'b1, 1'b0, 3'(k), 4'h9, 4'h7, 1'b1));
      look(3);
      chk({31'h0, ctl[0].src_req}, {31'h0, SRC_MAP[k]});
      chk({31'h0, ctl[0].dst_req}, {31'h0, DST_MAP[k]});
      chk({29'h0, ctl[0].flow}, 32'(k));
      chk({31'h0, ctl[0].lock}, 32'h1);
    end
    // one-hot reading of select 7 must not match
    @(posedge mclk);
    req <= 16'h0007;
    look(3);
    chk({31'h0, ctl[0].src_req}, 32'h0);
    // interrupt masks in both settings
    @(posedge mclk);
    irq <= 2'b11;
    look(2);
    chk({30'h0, ctl[1].tc_irq, ctl[0].tc_irq}, 32'h1);
    chk({30'h0, ctl[1].err_irq, ctl[0].err_irq}, 32'h0);
    v = cfg(1'b0, 1'b0, 1'b0, 1'b1, 3'h3, 4'h9, 4'h7, 1'b1);
    wr(CFG0_OFS, v);
    look(2);
    chk({30'h0, ctl[0].tc_irq, ctl[0].err_irq}, 32'h1);
    chk({31'h0, ctl[0].lock}, 32'h0);
    // fill, halt, drain while polling the active flag
    @(posedge mclk);
    irq <= 2'b00;
    req <= 16'h0280;
    look(6);
    rd(CFG0_OFS, v | 32'h0002_0000);
    v = v | 32'h0004_0000;
    wr(CFG0_OFS, v);
    look(2);
    chk({30'h0, ctl[0].src_req, ctl[0].dst_req}, 32'h1);
    chk({31'h0, ctl[0].halt}, 32'h1);
    @(posedge mclk);
    drain <= 2'b11;
    k = 0;
    do begin
      wb(1'b0, CFG0_OFS, 32'h0, q);
      k++;
    end while (q[ACTIVE_BIT] !== 1'b0 && k < 40);
    chk(q, v);
    // stop waits for the bus transfer, then flushes
    @(posedge mclk);
    busy <= 2'b01;
    wr(CFG0_OFS, v & 32'hffff_fffe);
    look(3);
    chk({31'h0, ctl[0].enable}, 32'h1);
    @(posedge mclk);
    busy <= 2'b00;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (ctl[0].fifo_flush !== 1'b1 && k < 6);
    chk({30'h0, ctl[0].enable, ctl[0].fifo_flush}, 32'h1);
    rd(CFG0_OFS, v & 32'hffff_fffe);
    rd(ENBL_OFS, 32'h0);
    // self disable on last list item, then on error
    v = cfg(1'b0, 1'b0, 1'b1, 1'b1, 3'h2, 4'h0, 4'h3, 1'b1);
    for (k = 0; k < 2; k++) begin
      wr(CFG1_OFS, v);
      rd(ENBL_OFS, 32'h2);
      @(posedge mclk);
      linked_list_item <= (k == 0) ? 2'b10 : 2'b00;
      err <= (k == 1) ? 2'b10 : 2'b00;
      @(posedge mclk);
      linked_list_item <= 2'b00;
      err <= 2'b00;
      look(2);
      chk({30'h0, ctl[1].enable, ctl[1].fifo_flush}, 32'h0);
      rd(CFG1_OFS, v & 32'hffff_fffe);
    end
    report_and_stop;
  end
endmodule : tb_dma_channel_config_and_ident
`default_nettype wire
